/* File: bfcs_pkg.sv */
// Constants, register map and types for the boot flash command sequencer host.
// Assumes a 200 MHz system clock; all pin timings are derived from it.
package bfcs_pkg;
   localparam int CLK_PERIOD_PS = 5000;
   // Pin timings in ns
   localparam int T_WP_NS = 50;
   localparam int T_WR_HIGH_NS = 20;
   localparam int T_RD_NS = 90;
   localparam int T_RST_REC_NS = 450;
   localparam int T_BOOT_LOCK_NS = 100;
   localparam int SYNC_STAGES = 2;

   function automatic logic [7:0] bfcs_cyc_min(input int ns);
      int c;
      c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      if (c < 1)
      begin
         c = 1;
      end
      return c[7:0];
   endfunction : bfcs_cyc_min

   localparam logic [7:0] WP_CYC = bfcs_cyc_min(T_WP_NS);
   localparam logic [7:0] WR_HIGH_CYC = bfcs_cyc_min(T_WR_HIGH_NS);
   localparam logic [7:0] RD_CYC = bfcs_cyc_min(T_RD_NS) + 8'(SYNC_STAGES);
   localparam logic [7:0] RST_REC_CYC = bfcs_cyc_min(T_RST_REC_NS);
   localparam logic [7:0] BOOT_LOCK_CYC = bfcs_cyc_min(T_BOOT_LOCK_NS);

   // Device command bytes
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
   localparam logic [7:0] CMD_PROG_SETUP_ALT = 8'h10;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
   localparam logic [7:0] CMD_ERASE_SUSPEND = 8'hB0;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam int WSM_READY_BIT = 7;

   // APB register byte offsets
   localparam logic [4:0] REG_OP = 5'h00;
   localparam logic [4:0] REG_ADDR = 5'h04;
   localparam logic [4:0] REG_WDATA = 5'h08;
   localparam logic [4:0] REG_RDATA = 5'h0C;
   localparam logic [4:0] REG_STATUS = 5'h10;
   localparam logic [4:0] REG_IRQ_STAT = 5'h14;
   localparam logic [4:0] REG_IRQ_MASK = 5'h18;
   localparam logic [4:0] REG_PIN_CTRL = 5'h1C;

   // Operation codes in REG_OP[1:0]
   localparam logic [1:0] OP_WRITE = 2'h0;
   localparam logic [1:0] OP_READ = 2'h1;
   localparam logic [1:0] OP_POLL = 2'h2;

   // PIN_CTRL fields
   localparam int PIN_RSTPD = 0;
   localparam int PIN_WP = 1;
   localparam int PIN_HV = 2;
   localparam int PIN_WORD = 3;
   // STATUS fields
   localparam int STS_BUSY = 0;
   localparam int STS_READY = 1;
   localparam int STS_RECOVERED = 2;
   localparam int STS_LOCKED = 3;
   // IRQ fields
   localparam int IRQ_DONE = 0;
   localparam int IRQ_READY = 1;
   localparam int IRQ_REFUSED = 2;

   localparam logic [3:0] PIN_CTRL_RST = 4'h9;
   localparam logic [2:0] IRQ_MASK_RST = 3'h0;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WR_SETUP = 3'b001,
      ST_WR_PULSE = 3'b010,
      ST_WR_GAP = 3'b011,
      ST_RD_WAIT = 3'b100,
      ST_RD_GAP = 3'b101
   } bfcs_state_type;
endpackage : bfcs_pkg

/* File: bfcs_sync.sv */
// Two-stage synchroniser for a bus of pin inputs.
// Assumes the inputs are quasi-static while sampled; bits may skew by a cycle.
`timescale 1ns/1ps
`default_nettype none
module bfcs_sync
   import bfcs_pkg::*;
#(
   parameter int WIDTH = 16
)
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta_r <= '0;
         q_o <= '0;
      end
      else
      begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end
endmodule : bfcs_sync
`default_nettype wire

/* File: bfcs_host.sv */
// Host controller that drives a boot-block flash through its strobe pins, ordered over APB.
// Assumes a flash on the pins with no clock of its own; dq_i is asynchronous.
`timescale 1ns/1ps
`default_nettype none
module bfcs_host
   import bfcs_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic irq_o,
   output logic ce_n_o,
   output logic we_n_o,
   output logic oe_n_o,
   output logic [19:0] addr_o,
   input wire logic [15:0] dq_i,
   output logic [15:0] dq_o,
   output logic [15:0] dq_oe_o,
   output logic reset_powerdown_n_o,
   output logic high_voltage_level_o,
   output logic write_protect_o,
   output logic word_mode_o
);
   typedef struct packed {
      bfcs_state_type st;
      logic [7:0] cnt;
      logic [7:0] rise_cnt;
      logic [1:0] op;
      logic ce_n;
      logic we_n;
      logic oe_n;
      logic [19:0] pin_addr;
      logic [15:0] pin_dq;
      logic dq_oe;
      logic [3:0] pins;
      logic word_mode;
      logic [19:0] addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic ready_seen;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic irq;
      logic pready;
      logic [31:0] prdata;
   } bfcs_regs_type;

   bfcs_regs_type s_r;
   bfcs_regs_type s_nxt;
   logic [15:0] dq_sync;

   bfcs_sync #(.WIDTH(16)) u_dq_sync
   (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .d_i(dq_i),
      .q_o(dq_sync)
   );

   always_comb
   begin
      logic wr_acc;
      logic rd_acc;
      logic [4:0] off;
      logic [2:0] irq_set;
      logic recovered;
      logic start;
      wr_acc = 1'b0;
      rd_acc = 1'b0;
      off = paddr_i[4:0];
      irq_set = 3'h0;
      recovered = 1'b0;
      start = 1'b0;
      s_nxt = s_r;

      // Access phase answered in its second cycle
      s_nxt.pready = psel_i & penable_i & ~s_r.pready;
      wr_acc = psel_i & penable_i & ~s_r.pready & pwrite_i;
      rd_acc = psel_i & penable_i & ~s_r.pready & ~pwrite_i;

      // Time since reset/power-down release, saturating
      if (!s_r.pins[PIN_RSTPD])
      begin
         s_nxt.rise_cnt = 8'h00;
      end
      else if (s_r.rise_cnt != 8'hFF)
      begin
         s_nxt.rise_cnt = s_r.rise_cnt + 8'h01;
      end
      recovered = s_r.pins[PIN_RSTPD] && (s_r.rise_cnt >= RST_REC_CYC);

      if (rd_acc)
      begin
         case (off)
            REG_OP: s_nxt.prdata = {30'h0, s_r.op};
            REG_ADDR: s_nxt.prdata = {12'h0, s_r.addr};
            REG_WDATA: s_nxt.prdata = {16'h0, s_r.wdata};
            REG_RDATA: s_nxt.prdata = {16'h0, s_r.rdata};
            REG_STATUS: s_nxt.prdata = {28'h0, s_r.pins[PIN_RSTPD] && (s_r.rise_cnt >= BOOT_LOCK_CYC),
                                        recovered, s_r.ready_seen, s_r.st != ST_IDLE};
            REG_IRQ_STAT: s_nxt.prdata = {29'h0, s_r.irq_stat};
            REG_IRQ_MASK: s_nxt.prdata = {29'h0, s_r.irq_mask};
            REG_PIN_CTRL: s_nxt.prdata = {28'h0, s_r.word_mode, s_r.pins[2:0]};
            default: s_nxt.prdata = 32'h0;
         endcase
      end

      if (wr_acc)
      begin
         case (off)
            REG_OP:
            begin
               // Ops before recovery or while busy are dropped
               if (s_r.st == ST_IDLE && recovered && pwdata_i[1:0] != 2'h3)
               begin
                  start = 1'b1;
                  s_nxt.op = pwdata_i[1:0];
               end
               else
               begin
                  irq_set[IRQ_REFUSED] = 1'b1;
               end
            end
            REG_ADDR: s_nxt.addr = pwdata_i[19:0];
            REG_WDATA: s_nxt.wdata = pwdata_i[15:0];
            REG_IRQ_MASK: s_nxt.irq_mask = pwdata_i[2:0];
            REG_PIN_CTRL:
            begin
               s_nxt.pins = pwdata_i[3:0];
               // Boot block writes need high voltage or write-protect high held through the op
               if (s_r.st != ST_IDLE)
               begin
                  s_nxt.pins[PIN_HV] = s_r.pins[PIN_HV];
                  s_nxt.pins[PIN_WP] = s_r.pins[PIN_WP];
                  s_nxt.pins[PIN_RSTPD] = s_r.pins[PIN_RSTPD];
               end
            end
            default: ;
         endcase
      end

      // Width select follows its bit only while in deep power-down
      if (!s_r.pins[PIN_RSTPD])
      begin
         s_nxt.word_mode = s_r.pins[PIN_WORD];
      end

      case (s_r.st)
         ST_IDLE:
         begin
            if (start)
            begin
               s_nxt.pin_addr = s_r.addr;
               s_nxt.cnt = 8'h00;
               if (pwdata_i[1:0] == OP_WRITE)
               begin
                  // Address and data settle before the strobes fall
                  s_nxt.pin_dq = s_r.wdata;
                  s_nxt.dq_oe = 1'b1;
                  s_nxt.st = ST_WR_SETUP;
               end
               else
               begin
                  s_nxt.ce_n = 1'b0;
                  s_nxt.oe_n = 1'b0;
                  s_nxt.st = ST_RD_WAIT;
               end
            end
         end
         ST_WR_SETUP:
         begin
            s_nxt.ce_n = 1'b0;
            s_nxt.we_n = 1'b0;
            s_nxt.st = ST_WR_PULSE;
         end
         ST_WR_PULSE:
         begin
            s_nxt.cnt = s_r.cnt + 8'h01;
            if (s_r.cnt == WP_CYC - 8'h01)
            begin
               // Write strobe rises first, ending the cycle; data held one more edge
               s_nxt.we_n = 1'b1;
               s_nxt.cnt = 8'h00;
               s_nxt.st = ST_WR_GAP;
            end
         end
         ST_WR_GAP:
         begin
            s_nxt.ce_n = 1'b1;
            s_nxt.dq_oe = 1'b0;
            s_nxt.cnt = s_r.cnt + 8'h01;
            // Strobes stay high for the write high width before the next op
            if (s_r.cnt == WR_HIGH_CYC - 8'h01)
            begin
               s_nxt.st = ST_IDLE;
               irq_set[IRQ_DONE] = 1'b1;
            end
         end
         ST_RD_WAIT:
         begin
            s_nxt.cnt = s_r.cnt + 8'h01;
            if (s_r.cnt == RD_CYC - 8'h01)
            begin
               s_nxt.rdata = dq_sync;
               s_nxt.ready_seen = dq_sync[WSM_READY_BIT];
               s_nxt.ce_n = 1'b1;
               s_nxt.oe_n = 1'b1;
               s_nxt.cnt = 8'h00;
               s_nxt.st = ST_RD_GAP;
            end
         end
         ST_RD_GAP:
         begin
            s_nxt.cnt = s_r.cnt + 8'h01;
            // Gap lets the flash release the data bus between polls
            if (s_r.cnt == WR_HIGH_CYC - 8'h01)
            begin
               s_nxt.cnt = 8'h00;
               if (s_r.op == OP_POLL && !s_r.ready_seen)
               begin
                  // Only the ready bit ends a poll; no timeout here
                  s_nxt.ce_n = 1'b0;
                  s_nxt.oe_n = 1'b0;
                  s_nxt.st = ST_RD_WAIT;
               end
               else
               begin
                  irq_set[IRQ_DONE] = 1'b1;
                  irq_set[IRQ_READY] = s_r.op == OP_POLL;
                  s_nxt.st = ST_IDLE;
               end
            end
         end
         default:
         begin
            s_nxt.st = ST_IDLE;
            s_nxt.ce_n = 1'b1;
            s_nxt.we_n = 1'b1;
            s_nxt.oe_n = 1'b1;
            s_nxt.dq_oe = 1'b0;
         end
      endcase

      // Set wins over a same-cycle clear
      if (wr_acc && off == REG_IRQ_STAT)
      begin
         s_nxt.irq_stat = s_r.irq_stat & ~pwdata_i[2:0];
      end
      s_nxt.irq_stat = s_nxt.irq_stat | irq_set;
      s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
   end

   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s_r <= '0;
         s_r.st <= ST_IDLE;
         s_r.ce_n <= 1'b1;
         s_r.we_n <= 1'b1;
         s_r.oe_n <= 1'b1;
         s_r.pins <= PIN_CTRL_RST;
         s_r.word_mode <= PIN_CTRL_RST[PIN_WORD];
         s_r.irq_mask <= IRQ_MASK_RST;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign prdata_o = s_r.prdata;
   assign pready_o = s_r.pready;
   assign pslverr_o = 1'b0;
   assign irq_o = s_r.irq;
   assign ce_n_o = s_r.ce_n;
   assign we_n_o = s_r.we_n;
   assign oe_n_o = s_r.oe_n;
   assign addr_o = s_r.pin_addr;
   assign dq_o = s_r.pin_dq;
   assign dq_oe_o = {16{s_r.dq_oe}};
   assign reset_powerdown_n_o = s_r.pins[PIN_RSTPD];
   assign high_voltage_level_o = s_r.pins[PIN_HV];
   assign write_protect_o = s_r.pins[PIN_WP];
   assign word_mode_o = s_r.word_mode;
endmodule : bfcs_host
`default_nettype wire

/* File: bfcs_host_sva.sv */
// Checker for the flash host pin and bus timing.
// Assumes a single clock domain and sees only top-level ports.
`timescale 1ns/1ps
`default_nettype none
module bfcs_host_sva
   import bfcs_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pready_o,
   input wire logic ce_n_o,
   input wire logic we_n_o,
   input wire logic oe_n_o,
   input wire logic [19:0] addr_o,
   input wire logic [15:0] dq_o,
   input wire logic [15:0] dq_oe_o,
   input wire logic reset_powerdown_n_o,
   input wire logic high_voltage_level_o,
   input wire logic write_protect_o,
   input wire logic word_mode_o
);
   logic [7:0] rec_cnt_r;
   // Saturates so a long idle spell cannot wrap into a false early start
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rec_cnt_r <= 8'h00;
      end
      else if (!reset_powerdown_n_o)
      begin
         rec_cnt_r <= 8'h00;
      end
      else if (rec_cnt_r != 8'hFF)
      begin
         rec_cnt_r <= rec_cnt_r + 8'h01;
      end
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   pulse_width_a: assert property (
      $fell(we_n_o) |-> (!we_n_o && !ce_n_o)[*8] ##1 !we_n_o ##1 !we_n_o ##1 we_n_o) else $error("write pulse width");
   write_gap_a: assert property (
      $rose(we_n_o) |-> we_n_o[*4]) else $error("write high gap too short");
   data_hold_a: assert property (
      !we_n_o |-> dq_oe_o == 16'hFFFF && $stable(dq_o) && $stable(addr_o)) else $error("write data moved");
   read_excl_a: assert property (
      !oe_n_o |-> we_n_o && dq_oe_o == 16'h0000) else $error("drive during read");
   read_hold_a: assert property (
      $fell(oe_n_o) |-> (!oe_n_o && !ce_n_o)[*8] ##1 !oe_n_o[*8] ##1 !oe_n_o[*4] ##1 oe_n_o) else $error("read window");
   pins_frozen_a: assert property (
      !ce_n_o |-> $stable(high_voltage_level_o) && $stable(write_protect_o) && reset_powerdown_n_o) else $error("pins moved");
   recovery_a: assert property (
      $fell(ce_n_o) |-> rec_cnt_r >= RST_REC_CYC) else $error("access before recovery");
   width_sel_a: assert property (
      $changed(word_mode_o) |-> !reset_powerdown_n_o || !$past(reset_powerdown_n_o)) else $error("width changed live");
   apb_answer_a: assert property (
      psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o) else $error("apb answer");
endmodule : bfcs_host_sva
bind bfcs_host bfcs_host_sva u_sva (.clk_sys_i, .rst_i, .psel_i, .penable_i, .pready_o, .ce_n_o, .we_n_o, .oe_n_o,
   .addr_o, .dq_o, .dq_oe_o, .reset_powerdown_n_o, .high_voltage_level_o, .write_protect_o, .word_mode_o);
`default_nettype wire

/* File: bfcs_flash_model.sv */
// Behavioural boot flash device for the host bench.
// Assumes strobes change just after clk_i edges; 16 words of array only.
`timescale 1ns/1ps
`default_nettype none
module bfcs_flash_model
#(
   parameter logic [15:0] ID_CODE = 16'h5A3C, // Arbitrary value
   parameter int BUSY_CYC = 200
)
(
   input wire logic clk_i,
   input wire logic ce_n_i,
   input wire logic we_n_i,
   input wire logic oe_n_i,
   input wire logic [19:0] addr_i,
   input wire logic [15:0] dq_i,
   output logic [15:0] dq_o
);
   logic [15:0] mem [16];
   logic [15:0] wd;
   logic [1:0] mode;
   logic wr_prev, prog_set, er_set, er_err, erasing, susp;
   int cnt, saved;
   wire wr_act = !ce_n_i && !we_n_i;
   wire [7:0] sts = {cnt == 0, susp, er_err, 5'h00};
   initial
   begin
      foreach (mem[i]) mem[i] = 16'hFFFF;
      {mode, wr_prev, prog_set, er_set, er_err, erasing, susp, cnt, dq_o} = '0;
   end
   always @(posedge clk_i)
   begin
      if (cnt == 1 && erasing)
      begin
         foreach (mem[i]) mem[i] = 16'hFFFF;
         erasing = 0;
      end
      if (cnt > 0) cnt = cnt - 1;
      if (wr_act) wd = dq_i;
      if (wr_prev && !wr_act)
      begin
         if (cnt != 0)
         begin
            if (erasing && wd[7:0] == 8'hB0) {saved, cnt, susp, mode} = {cnt, 32'd0, 1'b1, 2'd1};
         end
         else if (prog_set)
         begin
            mem[addr_i[3:0]] = mem[addr_i[3:0]] & wd;
            {prog_set, cnt, mode} = {1'b0, BUSY_CYC, 2'd1};
         end
         else if (er_set)
         begin
            if (wd[7:0] == 8'hD0) {cnt, erasing} = {BUSY_CYC * 2, 1'b1};
            else er_err = 1;
            {er_set, mode} = {1'b0, 2'd1};
         end
         else if (susp)
         begin
            if (wd[7:0] == 8'hD0) {susp, cnt} = {1'b0, saved};
            if (wd[7:0] == 8'hD0 || wd[7:0] == 8'h70) mode = 1;
            else if (wd[7:0] != 8'h10 && wd[7:0] != 8'h40 && wd[7:0] != 8'h90) mode = 0;
         end
         else
         begin
            case (wd[7:0])
               8'h10, 8'h40: {prog_set, mode} = {1'b1, 2'd1};
               8'h20: {er_set, mode} = {1'b1, 2'd1};
               8'h70: mode = 1;
               8'h90: mode = 2;
               8'h50: {er_err, mode} = 3'b000;
               default: mode = 0;
            endcase
         end
      end
      wr_prev = wr_act;
      // Released bus shows a moving pattern, never a held value
      if (!ce_n_i && !oe_n_i) dq_o <= mode == 0 ? mem[addr_i[3:0]] : mode == 2 ? ID_CODE : {8'h00, sts};
      else dq_o <= ~dq_o;
   end
endmodule : bfcs_flash_model
`default_nettype wire

/* File: bfcs_host_tb.sv */
// Self-checking bench: APB master, random program data, flash device model.
// Assumes the checker is bound inside the host.
`timescale 1ns/1ps
`default_nettype none
module bfcs_host_tb;
   import bfcs_pkg::*;
   logic clk_sys_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0;
   logic [31:0] paddr = '0, pwdata = '0, prdata, seed = 32'h68D77256, r;
   logic pready, pslverr, irq, ce_n, we_n, oe_n, pd_n, hv, wp, word;
   logic [19:0] faddr, a;
   logic [15:0] dqi, dqo, dqoe, v, d;
   int errors = 0, comparisons = 0, cyc = 0;
   bfcs_host u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq),
      .ce_n_o(ce_n), .we_n_o(we_n), .oe_n_o(oe_n), .addr_o(faddr), .dq_i(dqi), .dq_o(dqo), .dq_oe_o(dqoe),
      .reset_powerdown_n_o(pd_n), .high_voltage_level_o(hv), .write_protect_o(wp), .word_mode_o(word));
   bfcs_flash_model u_flash (.clk_i(clk_sys_i), .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(faddr),
      .dq_i(dqo & dqoe), .dq_o(dqi));
   initial forever #2.5 clk_sys_i = ~clk_sys_i;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   function automatic logic [15:0] exp_sts(input logic rdy, input logic sus, input logic err);
      return {8'h00, rdy, sus, err, 5'h00};
   endfunction : exp_sts
   task automatic print_verdict;
      $display("comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : print_verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [4:0] ad, input logic [31:0] wd);
      @(posedge clk_sys_i);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, 27'h0, ad, wd};
      @(posedge clk_sys_i);
      penable <= 1;
      do @(posedge clk_sys_i); while (pready !== 1'b1);
      r = prdata;
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic fop(input logic [1:0] op, input logic [19:0] ad, input logic [15:0] wd);
      apb(1, REG_ADDR, {12'h0, ad});
      apb(1, REG_WDATA, {16'h0, wd});
      apb(1, REG_OP, {30'h0, op});
      do apb(0, REG_STATUS, 0); while (r[STS_BUSY] !== 1'b0);
   endtask : fop
   task automatic frd(input logic [19:0] ad);
      fop(OP_READ, ad, 0);
      apb(0, REG_RDATA, 0);
      v = r[15:0];
   endtask : frd
   always @(posedge clk_sys_i)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         errors++;
         print_verdict();
      end
   end
   initial
   begin
      repeat (20) @(posedge clk_sys_i);
      rst_i <= 0;
      apb(0, REG_STATUS, 0);
      check(r[STS_LOCKED], 1'b0);
      apb(0, REG_PIN_CTRL, 0);
      check(r, 32'h9);
      apb(0, REG_IRQ_MASK, 0);
      check(r, 32'h0);
      apb(1, REG_OP, 0);
      apb(0, REG_IRQ_STAT, 0);
      check(r[IRQ_REFUSED], 1'b1);
      apb(1, REG_IRQ_STAT, 32'h4);
      apb(0, REG_IRQ_STAT, 0);
      check(r, 32'h0);
      do apb(0, REG_STATUS, 0); while (r[STS_RECOVERED] !== 1'b1);
      check(r[STS_LOCKED], 1'b1);
      apb(1, REG_IRQ_MASK, 32'h1);
      fop(OP_WRITE, 0, 16'h0090);
      check(irq, 1'b1);
      apb(1, REG_IRQ_STAT, 32'h7);
      repeat (2) @(posedge clk_sys_i);
      check(irq, 1'b0);
      apb(1, REG_IRQ_MASK, 32'h0);
      frd(0);
      check(v, 16'h5A3C);
      check(irq, 1'b0);
      for (int i = 0; i < 4; i++)
      begin
         seed = xs(seed);
         // Distinct low address bits, so each word is still erased
         a = {seed[19:2], i[1:0]};
         d = i == 0 ? 16'h00B0 : seed[31:16];
         fop(OP_WRITE, a, i[0] ? 16'h0010 : 16'h0040);
         fop(OP_WRITE, a, d);
         frd(a);
         check(v, exp_sts(0, 0, 0));
         fop(OP_POLL, a, 0);
         apb(0, REG_IRQ_STAT, 0);
         check(r[2:0], 3'h3);
         apb(1, REG_IRQ_STAT, 32'h7);
         fop(OP_WRITE, a, 16'h00FF);
         frd(a);
         check(v, d);
      end
      apb(0, REG_ADDR, 0);
      check(r, {12'h0, a});
      check(faddr, a);
      check(pslverr, 1'b0);
      fop(OP_WRITE, a, 16'h0020);
      fop(OP_WRITE, a, 16'h00D0);
      fop(OP_WRITE, a, 16'h00B0);
      fop(OP_WRITE, a, 16'h0090);
      frd(a);
      check(v, exp_sts(1, 1, 0));
      fop(OP_WRITE, a, 16'h00D0);
      fop(OP_POLL, a, 0);
      fop(OP_WRITE, a, 16'h00FF);
      frd(a);
      check(v, 16'hFFFF);
      fop(OP_WRITE, a, 16'h0020);
      fop(OP_WRITE, a, 16'h0070);
      frd(a);
      check(v, exp_sts(1, 0, 1));
      fop(OP_WRITE, a, 16'h00FF);
      frd(a);
      check(v, 16'hFFFF);
      apb(1, REG_PIN_CTRL, 32'h7);
      repeat (2) @(posedge clk_sys_i);
      check({wp, hv, word}, 3'b111);
      apb(1, REG_PIN_CTRL, 32'h0);
      repeat (2) @(posedge clk_sys_i);
      check({pd_n, word}, 2'b00);
      print_verdict();
   end
endmodule : bfcs_host_tb
`default_nettype wire
